// *** hdl/chr_pkg.sv ***
/*
 * chr_pkg: constants shared by the security header sender, the
 * receiver checker and the counter table.
 * assumes: a single clk_sys domain and a 32-bit APB master on the receiver.
 */
package chr_pkg;
    // ==========================================================
    // header layout
    localparam int HDR_BYTES = 5;
    localparam int HDR_BITS = HDR_BYTES * 8;
    localparam int OCT0_HI = 39;
    localparam int OCT0_LO = 32;
    localparam int CODE_HI = 2;
    localparam int CODE_LO = 0;
    localparam int KTYPE_HI = 4;
    localparam int KTYPE_LO = 3;
    localparam int KIDX_BIT = 6;
    localparam int RSVD_BIT = 7;

    // ==========================================================
    // tag length codes and key types
    localparam logic [2:0] CODE_POP = 3'h0;
    localparam logic [2:0] CODE_TAG4 = 3'h1;
    localparam logic [2:0] CODE_TAG8 = 3'h3;
    localparam logic [2:0] CODE_TAG16 = 3'h7;
    localparam logic [1:0] KEY_PAIRWISE = 2'h0;
    localparam logic [1:0] KEY_NODE_AUTH = 2'h1;
    localparam logic [1:0] KEY_BROADCAST = 2'h2;
    localparam logic [1:0] KEY_RESERVED = 2'h3;

    // ==========================================================
    // frame counter
    localparam logic [31:0] CNT_INIT = 32'h0000_0001;
    localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    localparam logic [31:0] CNT_ZERO = 32'h0000_0000;

    // ==========================================================
    // counter table geometry
    localparam int ORIG_W = 3;
    localparam int PRIO_W = 2;
    localparam int SLOT_W = 3;
    localparam int GEN_W = 4;
    localparam int TAB_AW = ORIG_W + PRIO_W + SLOT_W;
    localparam int TAB_DEPTH = 1 << TAB_AW;
    localparam int TAB_DW = GEN_W + 32;
    localparam int NUM_SLOTS = 1 << SLOT_W;

    // ==========================================================
    // receiver registers (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_KEYNEW = 8'h0C;
    localparam logic [7:0] REG_LASTFN = 8'h10;
    localparam logic [2:0] CTRL_LEVEL_RST = 3'h7;
    localparam int EV_W = 4;
    localparam int EV_ACCEPT = 0;
    localparam int EV_DROP_TAG = 1;
    localparam int EV_DROP_REPLAY = 2;
    localparam int EV_DROP_LEVEL = 3;
endpackage : chr_pkg

// *** hdl/chr_link_if.sv ***
/*
 * chr_link_if: carries one security header plus its frame context from the
 * sending node to the receiving node.
 * assumes: both ends on clk_sys; valid held until ready.
 */
`timescale 1ns/1ps
interface chr_link_if;
    logic hdrValid;
    logic hdrReady;
    logic [39:0] hdrData;
    logic [2:0] originator;
    logic [1:0] framePriority;

    modport tx (output hdrValid, output hdrData, output originator,
                output framePriority, input hdrReady);
    modport rx (input hdrValid, input hdrData, input originator,
                input framePriority, output hdrReady);
endinterface : chr_link_if

// *** hdl/chr_fn_table.sv ***
/*
 * chr_fn_table: last accepted counter store, one word per originator,
 * priority and key slot; registered read.
 * assumes: caller tracks entry validity itself.
 */
`timescale 1ns/1ps
module chr_fn_table (
    input wire logic clk_sys,
    input wire logic [chr_pkg::TAB_AW-1:0] rdAddr,
    output logic [chr_pkg::TAB_DW-1:0] rdData,
    input wire logic wrEn,
    input wire logic [chr_pkg::TAB_AW-1:0] wrAddr,
    input wire logic [chr_pkg::TAB_DW-1:0] wrData
);
    // ==========================================================
    // storage: no reset, so the receiver keeps a valid bit per entry
    logic [chr_pkg::TAB_DW-1:0] mem [chr_pkg::TAB_DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule : chr_fn_table

// *** hdl/chr_sender.sv ***
/*
 * chr_sender: builds the security header for each outgoing frame and owns
 * the frame counter.
 * assumes: the cipher outside takes aadHeader as covered data; the
 * receiver end answers through hdrReady.
 */
`timescale 1ns/1ps
module chr_sender (
    input wire logic clk_sys,
    input wire logic reset,
    chr_link_if.tx link,
    input wire logic sendReq,
    input wire logic [2:0] tagCode,
    input wire logic [1:0] keyType,
    input wire logic keyIdx,
    input wire logic [2:0] nodeId,
    input wire logic [1:0] segmentPriority,
    input wire logic newKey,
    output logic sendReady,
    output logic sendDone,
    output logic keyExhausted,
    output logic [39:0] aadHeader
);
    typedef struct packed {
        logic [31:0] cnt;
        logic [39:0] hdr;
        logic [2:0] orig;
        logic [1:0] prio;
        logic valid;
        logic done;
        logic exhausted;
    } chr_tx_state_t;

    chr_tx_state_t st;
    chr_tx_state_t next_st;
    logic pop;
    logic [7:0] ctl;

    // ==========================================================
    // header build and counter update
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        pop = (tagCode == chr_pkg::CODE_POP);
        ctl = 8'h00; // reserved bits stay zero
        ctl[chr_pkg::CODE_HI:chr_pkg::CODE_LO] = tagCode;
        ctl[chr_pkg::KTYPE_HI:chr_pkg::KTYPE_LO] = pop ? chr_pkg::KEY_PAIRWISE : keyType;
        ctl[chr_pkg::KIDX_BIT] = pop ? 1'b0 : keyIdx;
        if (st.valid && link.hdrReady) begin
            next_st.valid = 1'b0;
            next_st.done = 1'b1;
        end
        if (newKey) begin
            next_st.cnt = chr_pkg::CNT_INIT;
            next_st.exhausted = 1'b0;
        end else if (sendReq && !st.valid) begin
            if (!pop && st.cnt == chr_pkg::CNT_MAX) begin
                // never reuse a value: refuse until a fresh key
                next_st.exhausted = 1'b1;
            end else begin
                next_st.hdr = {ctl, st.cnt}; // octet 0 then counter msb first
                next_st.orig = nodeId;
                next_st.prio = segmentPriority;
                next_st.valid = 1'b1;
                if (pop && st.cnt == chr_pkg::CNT_MAX) begin
                    next_st.cnt = chr_pkg::CNT_ONE; // wraps past zero
                end else begin
                    next_st.cnt = st.cnt + chr_pkg::CNT_ONE;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '{cnt: chr_pkg::CNT_INIT, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs; header also goes to the cipher as covered data
    assign link.hdrValid = st.valid;
    assign link.hdrData = st.hdr;
    assign link.originator = st.orig;
    assign link.framePriority = st.prio;
    assign aadHeader = st.hdr;
    assign sendReady = !st.valid;
    assign sendDone = st.done;
    assign keyExhausted = st.exhausted;
endmodule : chr_sender

// *** hdl/chr_receiver.sv ***
/*
 * chr_receiver: checks each incoming security header, picks the key for the
 * cipher, and drops replayed, stale or wrongly protected frames.
 * assumes: tagOk comes from the cipher in the cycle the header is taken;
 * software sets the domain level and reports key changes over APB.
 */
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module chr_receiver (
    input wire logic clk_sys,
    input wire logic reset,
    chr_link_if.rx link,
    input wire logic tagOk,
    output logic [1:0] keyTypeSel,
    output logic keyIdxSel,
    output logic frameAccept,
    output logic frameDrop,
    output logic [31:0] acceptedCount,
    output logic irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef enum logic [1:0] {IDLE, LOOK, DECIDE} chr_rx_phase_t;

    typedef struct packed {
        chr_rx_phase_t phase;
        logic [39:0] hdr;
        logic [chr_pkg::TAB_AW-1:0] addr;
        logic tagGood;
        logic [chr_pkg::TAB_DEPTH-1:0] entryValid;
        logic [chr_pkg::NUM_SLOTS-1:0][chr_pkg::GEN_W-1:0] gen;
        logic [2:0] level;
        logic [chr_pkg::EV_W-1:0] status;
        logic [chr_pkg::EV_W-1:0] mask;
        logic [31:0] lastCnt;
        logic [31:0] rdata;
        logic err;
        logic [1:0] keyType;
        logic keyIdx;
        logic accept;
        logic drop;
    } chr_rx_state_t;

    chr_rx_state_t st;
    chr_rx_state_t next_st;
    logic [chr_pkg::TAB_DW-1:0] tabRd;
    logic [chr_pkg::TAB_DW-1:0] tabWr;
    logic tabWe;
    logic [7:0] ctl;
    logic pop;
    logic [2:0] code;
    logic [1:0] ktype;
    logic kidx;
    logic [chr_pkg::SLOT_W-1:0] slot;
    logic [31:0] frameCnt;
    logic formatBad;
    logic levelBad;
    logic replayBad;
    logic [chr_pkg::EV_W-1:0] events;
    logic apbWr;
    logic apbSetup;

    // ==========================================================
    // header fields of the captured frame
    always_comb begin
        ctl = st.hdr[chr_pkg::OCT0_HI:chr_pkg::OCT0_LO]; // octet 0
        frameCnt = st.hdr[31:0];
        code = ctl[chr_pkg::CODE_HI:chr_pkg::CODE_LO];
        pop = (code == chr_pkg::CODE_POP);
        // order-only frames: all other control bits are don't-care
        ktype = pop ? chr_pkg::KEY_PAIRWISE : ctl[chr_pkg::KTYPE_HI:chr_pkg::KTYPE_LO];
        kidx = pop ? 1'b0 : ctl[chr_pkg::KIDX_BIT]; // bit 7 unread
        slot = {ktype, kidx};
        formatBad = !pop && ((code != chr_pkg::CODE_TAG4 && code != chr_pkg::CODE_TAG8 &&
                    code != chr_pkg::CODE_TAG16) || ktype == chr_pkg::KEY_RESERVED);
        // exact match also rejects anything weaker than the domain
        levelBad = (code != st.level);
        // a key change bumps the slot generation, retiring old entries
        replayBad = (frameCnt == chr_pkg::CNT_ZERO) ||
                    (st.entryValid[st.addr] &&
                     tabRd[chr_pkg::TAB_DW-1:32] == st.gen[slot] && frameCnt <= tabRd[31:0]);
    end

    // ==========================================================
    // frame check sequence, registers and events
    always_comb begin
        next_st = st;
        next_st.accept = 1'b0;
        next_st.drop = 1'b0;
        events = '0;
        tabWe = 1'b0;
        tabWr = {st.gen[slot], frameCnt};
        apbSetup = psel && !penable;
        apbWr = psel && penable && pwrite;
        unique case (st.phase)
            IDLE: begin
                if (link.hdrValid) begin
                    next_st.hdr = link.hdrData; // header arrives clear
                    next_st.tagGood = tagOk;
                    // originator and first-segment priority index the table
                    next_st.addr = {link.originator, link.framePriority,
                                    chr_pkg::SLOT_W'(0)};
                    next_st.phase = LOOK;
                end
            end
            LOOK: begin
                next_st.addr = {st.addr[chr_pkg::TAB_AW-1:chr_pkg::SLOT_W], slot};
                next_st.keyType = ktype; // key handed to the cipher
                next_st.keyIdx = kidx;
                next_st.phase = DECIDE;
            end
            DECIDE: begin
                next_st.phase = IDLE;
                if (formatBad || levelBad) begin
                    events[chr_pkg::EV_DROP_LEVEL] = 1'b1;
                end else if (!pop && !st.tagGood) begin
                    events[chr_pkg::EV_DROP_TAG] = 1'b1;
                end else if (replayBad) begin
                    events[chr_pkg::EV_DROP_REPLAY] = 1'b1;
                end else begin
                    events[chr_pkg::EV_ACCEPT] = 1'b1;
                    tabWe = 1'b1; // only after every check passed
                    next_st.entryValid[st.addr] = 1'b1;
                    next_st.lastCnt = frameCnt;
                end
                next_st.accept = events[chr_pkg::EV_ACCEPT];
                next_st.drop = !events[chr_pkg::EV_ACCEPT];
            end
            default: next_st.phase = IDLE;
        endcase
        // apb: read data latched in setup so the access phase needs no wait
        if (apbSetup) begin
            next_st.err = 1'b0;
            next_st.rdata = 32'h0000_0000;
            unique case (paddr)
                chr_pkg::REG_CTRL: next_st.rdata = {29'h0000_0000, st.level};
                chr_pkg::REG_STATUS: next_st.rdata = {28'h000_0000, st.status};
                chr_pkg::REG_MASK: next_st.rdata = {28'h000_0000, st.mask};
                chr_pkg::REG_KEYNEW: next_st.rdata = 32'h0000_0000;
                chr_pkg::REG_LASTFN: next_st.rdata = st.lastCnt;
                default: next_st.err = 1'b1;
            endcase
        end
        // w1c first, then new events, so a same-cycle event survives
        if (apbWr && paddr == chr_pkg::REG_STATUS) begin
            next_st.status = st.status & ~pwdata[chr_pkg::EV_W-1:0];
        end
        next_st.status = next_st.status | events;
        if (apbWr && paddr == chr_pkg::REG_CTRL) begin
            next_st.level = pwdata[2:0];
        end
        if (apbWr && paddr == chr_pkg::REG_MASK) begin
            next_st.mask = pwdata[chr_pkg::EV_W-1:0];
        end
        if (apbWr && paddr == chr_pkg::REG_KEYNEW) begin
            // new key for a slot: earlier counters no longer bind
            next_st.gen[pwdata[chr_pkg::SLOT_W-1:0]] =
                st.gen[pwdata[chr_pkg::SLOT_W-1:0]] + chr_pkg::GEN_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '{phase: IDLE, level: chr_pkg::CTRL_LEVEL_RST, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // counter table; read address follows the state so data lands in DECIDE
    chr_fn_table u_table (
        .clk_sys(clk_sys),
        .rdAddr(next_st.addr),
        .rdData(tabRd),
        .wrEn(tabWe),
        .wrAddr(st.addr),
        .wrData(tabWr)
    );

    // ==========================================================
    // outputs
    assign link.hdrReady = (st.phase == IDLE);
    assign keyTypeSel = st.keyType;
    assign keyIdxSel = st.keyIdx;
    assign frameAccept = st.accept;
    assign frameDrop = st.drop;
    assign acceptedCount = st.lastCnt;
    assign irq = |(st.status & st.mask);
    assign prdata = st.rdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && st.err;
endmodule : chr_receiver

// *** dv/chr_link_properties.sv ***
/* chr_link_properties: timing and format assertions on the header link.
   assumes: instantiated in tb beside chr_link_if; one clk_sys domain. */
`timescale 1ns/1ps
module chr_link_properties (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hdrValid,
    input wire logic hdrReady,
    input wire logic [39:0] hdrData,
    input wire logic [2:0] originator,
    input wire logic [1:0] framePriority
);
    // ==========================================================
    // handshake and header format
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic take;
    // a header counts as passed only on the edge where both sides agree
    assign take = hdrValid && hdrReady;
    a_offer_held: assert property (
        hdrValid && !hdrReady |=> hdrValid && $stable(hdrData)) else $error("header moved early");
    a_context_held: assert property (
        hdrValid && !hdrReady |=> $stable({originator, framePriority}))
        else $error("context moved early");
    a_code_legal: assert property (
        hdrValid |-> hdrData[34:32] inside {3'h0, 3'h1, 3'h3, 3'h7}) else $error("bad tag code");
    a_key_legal: assert property (
        hdrValid && hdrData[34:32] != 3'h0 |-> hdrData[36:35] != 2'h3) else $error("bad key type");
    a_rsvd_zero: assert property (
        hdrValid |-> !hdrData[39] && !hdrData[37]) else $error("reserved bit set");
    a_fn_nonzero: assert property (
        hdrValid |-> hdrData[31:0] != 32'h0000_0000) else $error("zero counter sent");
    a_offer_once: assert property (
        take |=> !hdrValid) else $error("header offered twice");
    a_check_gap: assert property (
        take |=> !hdrReady [*2] ##1 hdrReady) else $error("check window wrong");
endmodule : chr_link_properties

// *** dv/tb.sv ***
/* tb: drives sender and receiver back to back, checks headers, verdicts,
   status and irq. assumes: both ends on clk_sys, receiver regs over APB. */
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
    logic clk_sys, reset, sendReq, keyIdx, newKey, tagOk, psel, penable, pwrite, err;
    logic keyIdxSel, frameAccept, frameDrop, irq, pready, pslverr, sendReady, sendDone;
    logic keyExhausted;
    logic [2:0] tagCode, nodeId;
    logic [1:0] keyType, segmentPriority, keyTypeSel;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, acceptedCount, rd, cntExp;
    logic [39:0] aadHeader;
    logic [3:0] maskSet;
    logic [2:0] codes [3] = '{3'h1, 3'h3, 3'h7};
    logic [1:0] kts [3] = '{2'h0, 2'h1, 2'h2};
    int mismatches = 0;
    int nTests = 0;
    int cycles = 0;

    // ==========================================================
    // the two ends joined by the link
    chr_link_if link();
    chr_sender chr_sender_i (.clk_sys(clk_sys), .reset(reset), .link(link.tx),
        .sendReq(sendReq), .tagCode(tagCode), .keyType(keyType), .keyIdx(keyIdx),
        .nodeId(nodeId), .segmentPriority(segmentPriority), .newKey(newKey),
        .sendReady(sendReady), .sendDone(sendDone), .keyExhausted(keyExhausted),
        .aadHeader(aadHeader));
    chr_receiver chr_receiver_i (.clk_sys(clk_sys), .reset(reset), .link(link.rx),
        .tagOk(tagOk), .keyTypeSel(keyTypeSel), .keyIdxSel(keyIdxSel),
        .frameAccept(frameAccept), .frameDrop(frameDrop), .acceptedCount(acceptedCount),
        .irq(irq),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    chr_link_properties chr_link_properties_i (.clk_sys(clk_sys), .reset(reset),
        .hdrValid(link.hdrValid), .hdrReady(link.hdrReady), .hdrData(link.hdrData),
        .originator(link.originator), .framePriority(link.framePriority));

    // ==========================================================
    // clock, hang guard and verdict
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    // a frame costs about a dozen cycles; the ceiling leaves a wide margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            testDone();
        end
    end
    task automatic testDone();
        $display("comparisons %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : testDone

    // expected header: control octet then counter, bit 5 and bit 7 zero
    function automatic logic [39:0] hdrOf(input logic [2:0] c, input logic [1:0] kt,
                                          input logic ki, input logic [31:0] cnt);
        return {1'b0, ki, 1'b0, kt, c, cnt};
    endfunction : hdrOf

    // ==========================================================
    // bus and frame tasks
    // request held until pready is seen high at an edge; no wait count assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        // no wait count assumed: only the hang guard ends a stuck access
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    // ev: 0 accept, 1 tag drop, 2 replay drop, 3 level drop
    task automatic send(input logic [2:0] c, input logic [1:0] kt, input logic ki,
                        input logic [2:0] nd, input logic [1:0] pr, input logic ok, input int ev);
        @(posedge clk_sys);
        sendReq <= 1;
        tagCode <= c;
        keyType <= kt;
        keyIdx <= ki;
        nodeId <= nd;
        segmentPriority <= pr;
        tagOk <= ok;
        @(posedge clk_sys);
        sendReq <= 0;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            if (link.hdrValid && link.hdrReady) break;
        end
        `CHK(link.hdrData[34:32], c)
        if (c != 3'h0) `CHK(link.hdrData, hdrOf(c, kt, ki, cntExp))
        `CHK(link.hdrData[31:0], cntExp)
        `CHK(aadHeader, link.hdrData)
        `CHK({link.originator, link.framePriority}, {nd, pr})
        `CHK(sendReady, 1'b0)
        cntExp++;
        // the cycle after the take: done pulse stands and the sender is free again
        @(negedge clk_sys);
        `CHK({sendDone, sendReady}, 2'b11)
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            if (frameAccept || frameDrop) break;
        end
        `CHK({frameAccept, frameDrop}, {ev == 0, ev != 0})
        if (ev == 0) `CHK(acceptedCount, cntExp - 1)
        `CHK({keyTypeSel, keyIdxSel}, c != 3'h0 ? {kt, ki} : 3'h0)
        apb(0, 8'h04, 32'h0000_0000);
        `CHK(rd[3:0], 4'h1 << ev)
        @(negedge clk_sys);
        `CHK(irq, |(maskSet & (4'h1 << ev)))
        apb(1, 8'h04, 32'h0000_000F);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
    endtask : send

    // ==========================================================
    // main sequence
    initial begin
        {reset, sendReq, tagCode, keyType, keyIdx, nodeId, segmentPriority} = 13'h1000;
        {newKey, tagOk, psel, penable, pwrite, paddr, pwdata} = 45'h0;
        maskSet = 4'h0;
        cntExp = 32'h0000_0001;
        void'($urandom(32'h7e3c_ac64));
        repeat (8) @(posedge clk_sys);
        reset <= 0;
        // reset values and an unmapped place
        apb(0, 8'h00, 32'h0000_0000);
        `CHK(rd[2:0], 3'h7)
        apb(0, 8'h08, 32'h0000_0000);
        `CHK(rd[3:0], 4'h0)
        apb(0, 8'h14, 32'h0000_0000);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        `CHK(keyExhausted, 1'b0)
        // mask still clear, so this accept leaves irq low
        send(3'h7, 2'h0, 0, 3'h6, 2'h2, 1, 0);
        apb(1, 8'h08, 32'h0000_000F);
        maskSet = 4'hF;
        // each tagged level (codes 1, 3, 7) with random keys, nodes and priorities
        for (int l = 0; l < 3; l++) begin
            apb(1, 8'h00, {29'h0, codes[l]});
            repeat (3) send(codes[l], kts[$urandom_range(2)], 1'($urandom),
                            3'($urandom_range(5)), 2'($urandom), 1, 0);
        end
        send(3'h7, 2'h2, 1, 3'h7, 2'h1, 0, 1);
        send(3'h3, 2'h0, 0, 3'h7, 2'h1, 1, 3);
        // sender changes key alone: counter restarts and is seen as a replay
        @(posedge clk_sys);
        newKey <= 1;
        @(posedge clk_sys);
        newKey <= 0;
        cntExp = 32'h0000_0001;
        send(3'h7, 2'h0, 0, 3'h6, 2'h2, 1, 2);
        send(3'h7, 2'h0, 0, 3'h6, 2'h3, 1, 0);
        // software retires slot 0 and the sender restarts: counter 1 is fresh again
        apb(1, 8'h0C, 32'h0000_0000);
        @(posedge clk_sys);
        newKey <= 1;
        @(posedge clk_sys);
        newKey <= 0;
        cntExp = 32'h0000_0001;
        send(3'h7, 2'h0, 0, 3'h6, 2'h2, 1, 0);
        // order-only: tag verdict and key bits are ignored
        apb(1, 8'h00, 32'h0000_0000);
        repeat (2) send(3'h0, 2'h3, 1, 3'h7, 2'h0, 0, 0);
        // request held over two frames: the second offer waits out the first check
        @(posedge clk_sys);
        sendReq <= 1;
        repeat (3) @(posedge clk_sys);
        sendReq <= 0;
        repeat (8) @(posedge clk_sys);
        `CHK(acceptedCount, cntExp + 32'h0000_0001)
        testDone();
    end
endmodule : tb
